// ---- hdl/tap_map.svh ----
// Purpose: named constants of the boundary-scan access logic
// Assumes: included by the package and by every module that needs them
// Notes:   definitions only
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH

// ----------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------
`define IR_LEN        3
`define IR_EXTEST     3'h0
`define IR_SAMPLE     3'h1
`define IR_USER1      3'h2
`define IR_USER2      3'h3
`define IR_READBACK   3'h4
`define IR_CONFIG     3'h5
`define IR_BYPASS     3'h7
`define IR_CAPTURE    3'h1

// ----------------------------------------------------------------------
// boundary cell layout
// ----------------------------------------------------------------------
`define CELL_BITS     3
`define CELL_IN       0
`define CELL_OUT      1
`define CELL_OE       2
`define CELL_COUNT_DEF 8

// ----------------------------------------------------------------------
// synchroniser
// ----------------------------------------------------------------------
`define TAP_PIN_COUNT 3
`define TAP_PIN_TCK   0
`define TAP_PIN_TMS   1
`define TAP_PIN_TDI   2

`endif

// ---- hdl/tap_pkg.sv ----
// Purpose: types of the boundary-scan access logic
// Assumes: tap_map.svh holds the numeric constants
// Notes:   state codes are one-hot
`include "tap_map.svh"

package tap_pkg;

	// ------------------------------------------------------------------
	// controller states
	// ------------------------------------------------------------------
	typedef enum logic [15:0] {
		st_reset    = 16'h0001,
		st_idle     = 16'h0002,
		st_sel_dr   = 16'h0004,
		st_cap_dr   = 16'h0008,
		st_shift_dr = 16'h0010,
		st_exit1_dr = 16'h0020,
		st_pause_dr = 16'h0040,
		st_exit2_dr = 16'h0080,
		st_upd_dr   = 16'h0100,
		st_sel_ir   = 16'h0200,
		st_cap_ir   = 16'h0400,
		st_shift_ir = 16'h0800,
		st_exit1_ir = 16'h1000,
		st_pause_ir = 16'h2000,
		st_exit2_ir = 16'h4000,
		st_upd_ir   = 16'h8000
	} tap_state_t;

	// ------------------------------------------------------------------
	// selected data path
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		dr_bypass   = 3'h0,
		dr_extest   = 3'h1,
		dr_sample   = 3'h2,
		dr_user1    = 3'h3,
		dr_user2    = 3'h4,
		dr_config   = 3'h5,
		dr_readback = 3'h6
	} dr_sel_t;

endpackage

// ---- hdl/pin_edge_sync.sv ----
// Purpose: two-stage synchroniser for pin inputs, edge detect on bit 0
// Assumes: inputs are asynchronous to clk_sys
// Notes:   rise and fall are one-cycle pulses
`timescale 1ns/100ps

module pin_edge_sync
	import tap_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out,
	output logic                  rise,
	output logic                  fall
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic             last_reg;

	// ------------------------------------------------------------------
	// per-bit two flip-flop stages
	// ------------------------------------------------------------------
	// stages keep sampling in reset so no false edge follows release
	for (genvar i = 0; i < WIDTH; i++) begin : g_sync
		always_ff @(posedge clk_sys) begin
			stage1_reg[i] <= async_in[i];
			stage2_reg[i] <= stage1_reg[i];
		end
	end

	// ------------------------------------------------------------------
	// edge detect on the settled bit 0
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		last_reg <= stage2_reg[0];
	end

	assign sync_out = stage2_reg;
	assign rise     = stage2_reg[0] & ~last_reg & ~rst;
	assign fall     = ~stage2_reg[0] & last_reg & ~rst;

endmodule

// ---- hdl/boundary_scan_tap.sv ----
// Purpose: boundary-scan test access logic with user and configuration paths
// Assumes: tck, tms, tdi arrive from pins; clk_sys much faster than tck
// Notes:   tck is sampled, not used as a clock
`timescale 1ns/100ps
`include "tap_map.svh"

module boundary_scan_tap
	import tap_pkg::*;
#(
	parameter int N_CELLS = `CELL_COUNT_DEF
) (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic               scan_option,
	input  wire logic               tck_pin,
	input  wire logic               tms_pin,
	input  wire logic               tdi_pin,
	output logic                    tdo_pin_out,
	output logic                    tdo_pin_oe,
	input  wire logic               user_pin_out,
	input  wire logic               user_pin_oe,
	input  wire logic               config_active,
	input  wire logic               config_done,
	input  wire logic               public_en,
	input  wire logic               usercode_en,
	input  wire logic [N_CELLS-1:0] pad_in,
	output logic      [N_CELLS-1:0] pad_out,
	output logic      [N_CELLS-1:0] pad_oe,
	input  wire logic [N_CELLS-1:0] core_out,
	input  wire logic [N_CELLS-1:0] core_oe,
	output logic      [N_CELLS-1:0] core_in,
	output logic                    user_reset,
	output logic                    user_update,
	output logic                    user_shift,
	output logic                    user1_sel,
	output logic                    user2_sel,
	output logic                    user_tdi,
	input  wire logic               user1_tdo,
	input  wire logic               user2_tdo,
	output logic                    cfg_bit,
	output logic                    cfg_bit_valid,
	output logic                    readback_next,
	input  wire logic               readback_bit
);

	localparam int CHAIN = N_CELLS * `CELL_BITS;

	logic [`TAP_PIN_COUNT-1:0] tap_sync;
	logic [N_CELLS-1:0]        pad_sync;
	logic                      tck_rise;
	logic                      tck_fall;
	logic                      tms;
	logic                      tdi;
	tap_state_t                state_reg;
	tap_state_t                state_next;
	logic [`IR_LEN-1:0]        ir_shift_reg;
	logic [`IR_LEN-1:0]        ir_reg;
	dr_sel_t                   dr_sel;
	logic                      pub_ok;
	logic                      bsr_sel;
	logic                      user_sel;
	logic [CHAIN-1:0]          bsr_shift_reg;
	logic [CHAIN-1:0]          bsr_upd_reg;
	logic [CHAIN-1:0]          cap_vec;
	logic [N_CELLS-1:0]        drv_out;
	logic [N_CELLS-1:0]        drv_oe;
	logic                      bypass_reg;
	logic                      dr_tdo;
	logic                      tdo_reg;
	logic                      tdo_oe_reg;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	pin_edge_sync #(
		.WIDTH (`TAP_PIN_COUNT)
	) u_tap_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in ({tdi_pin, tms_pin, tck_pin}),
		.sync_out (tap_sync),
		.rise     (tck_rise),
		.fall     (tck_fall)
	);

	pin_edge_sync #(
		.WIDTH (N_CELLS)
	) u_pad_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in (pad_in),
		.sync_out (pad_sync),
		.rise     (),
		.fall     ()
	);

	assign tms = tap_sync[`TAP_PIN_TMS];
	assign tdi = tap_sync[`TAP_PIN_TDI];

	// ------------------------------------------------------------------
	// controller state machine
	// ------------------------------------------------------------------
	always_comb begin
		case (state_reg)
			st_reset:    state_next = tms ? st_reset    : st_idle;
			st_idle:     state_next = tms ? st_sel_dr   : st_idle;
			st_sel_dr:   state_next = tms ? st_sel_ir   : st_cap_dr;
			st_cap_dr:   state_next = tms ? st_exit1_dr : st_shift_dr;
			st_shift_dr: state_next = tms ? st_exit1_dr : st_shift_dr;
			st_exit1_dr: state_next = tms ? st_upd_dr   : st_pause_dr;
			st_pause_dr: state_next = tms ? st_exit2_dr : st_pause_dr;
			st_exit2_dr: state_next = tms ? st_upd_dr   : st_shift_dr;
			st_upd_dr:   state_next = tms ? st_sel_dr   : st_idle;
			st_sel_ir:   state_next = tms ? st_reset    : st_cap_ir;
			st_cap_ir:   state_next = tms ? st_exit1_ir : st_shift_ir;
			st_shift_ir: state_next = tms ? st_exit1_ir : st_shift_ir;
			st_exit1_ir: state_next = tms ? st_upd_ir   : st_pause_ir;
			st_pause_ir: state_next = tms ? st_exit2_ir : st_pause_ir;
			st_exit2_ir: state_next = tms ? st_upd_ir   : st_shift_ir;
			st_upd_ir:   state_next = tms ? st_sel_dr   : st_idle;
			default:     state_next = st_reset;
		endcase
	end

	// option off parks the controller; tms high holds it in reset
	always_ff @(posedge clk_sys) begin
		if (rst || !scan_option) begin
			state_reg <= st_reset;
		end else if (tck_rise) begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------
	// instruction register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ir_shift_reg <= `IR_BYPASS;
		end else if (tck_rise && state_reg == st_cap_ir) begin
			ir_shift_reg <= `IR_CAPTURE;
		end else if (tck_rise && state_reg == st_shift_ir) begin
			ir_shift_reg <= {tdi, ir_shift_reg[`IR_LEN-1:1]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || state_reg == st_reset) begin
			ir_reg <= `IR_BYPASS;
		end else if (tck_fall && state_reg == st_upd_ir) begin
			ir_reg <= ir_shift_reg;
		end
	end

	// ------------------------------------------------------------------
	// instruction decode and availability
	// ------------------------------------------------------------------
	always_comb begin
		dr_sel = dr_bypass;
		pub_ok = !config_done || public_en;
		case (ir_reg)
			`IR_EXTEST: begin
				if (pub_ok && !config_active) begin
					dr_sel = dr_extest;
				end
			end
			`IR_SAMPLE: begin
				if (pub_ok) begin
					dr_sel = dr_sample;
				end
			end
			`IR_USER1: begin
				if (config_done && usercode_en) begin
					dr_sel = dr_user1;
				end
			end
			`IR_USER2: begin
				if (config_done && usercode_en) begin
					dr_sel = dr_user2;
				end
			end
			`IR_READBACK: begin
				if (config_done && public_en) begin
					dr_sel = dr_readback;
				end
			end
			`IR_CONFIG: begin
				if (pub_ok) begin
					dr_sel = dr_config;
				end
			end
			default: begin
				dr_sel = dr_bypass;
			end
		endcase
	end

	assign bsr_sel  = (dr_sel == dr_extest) || (dr_sel == dr_sample);
	assign user_sel = (dr_sel == dr_user1) || (dr_sel == dr_user2);

	// ------------------------------------------------------------------
	// boundary register, three bits per pin cell
	// ------------------------------------------------------------------
	for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
		// core out and oe are captured too, so internal nodes are visible
		assign cap_vec[i*`CELL_BITS+`CELL_IN]  = pad_sync[i];
		assign cap_vec[i*`CELL_BITS+`CELL_OUT] = core_out[i];
		assign cap_vec[i*`CELL_BITS+`CELL_OE]  = core_oe[i];
		// every cell drives as its own bidirectional pin under extest
		assign drv_out[i] = (dr_sel == dr_extest) ? bsr_upd_reg[i*`CELL_BITS+`CELL_OUT] : core_out[i];
		assign drv_oe[i]  = (dr_sel == dr_extest) ? bsr_upd_reg[i*`CELL_BITS+`CELL_OE]  : core_oe[i];
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bsr_shift_reg <= '0;
		end else if (tck_rise && bsr_sel && state_reg == st_cap_dr) begin
			bsr_shift_reg <= cap_vec;
		end else if (tck_rise && bsr_sel && state_reg == st_shift_dr) begin
			bsr_shift_reg <= {tdi, bsr_shift_reg[CHAIN-1:1]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bsr_upd_reg <= '0;
		end else if (tck_fall && bsr_sel && state_reg == st_upd_dr) begin
			bsr_upd_reg <= bsr_shift_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pad_out <= '0;
			pad_oe  <= '0;
			core_in <= '0;
		end else begin
			pad_out <= drv_out;
			pad_oe  <= drv_oe;
			core_in <= pad_sync;
		end
	end

	// ------------------------------------------------------------------
	// bypass bit, also carries configuration data
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bypass_reg <= 1'b0;
		end else if (tck_rise && state_reg == st_cap_dr) begin
			bypass_reg <= 1'b0;
		end else if (tck_rise && state_reg == st_shift_dr) begin
			bypass_reg <= tdi;
		end
	end

	// ------------------------------------------------------------------
	// configuration load and readback
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cfg_bit       <= 1'b0;
			cfg_bit_valid <= 1'b0;
			readback_next <= 1'b0;
		end else begin
			cfg_bit_valid <= tck_rise && state_reg == st_shift_dr && dr_sel == dr_config;
			readback_next <= tck_rise && state_reg == st_shift_dr && dr_sel == dr_readback;
			if (tck_rise && state_reg == st_shift_dr && dr_sel == dr_config) begin
				cfg_bit <= tdi;
			end
		end
	end

	// ------------------------------------------------------------------
	// user register strobes
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			user_reset  <= 1'b1;
			user_update <= 1'b0;
			user_shift  <= 1'b0;
			user1_sel   <= 1'b0;
			user2_sel   <= 1'b0;
			user_tdi    <= 1'b0;
		end else begin
			user_reset  <= state_reg == st_reset;
			user_update <= tck_fall && user_sel && state_reg == st_upd_dr;
			user_shift  <= user_sel && state_reg == st_shift_dr;
			user1_sel   <= dr_sel == dr_user1;
			user2_sel   <= dr_sel == dr_user2;
			user_tdi    <= tdi;
		end
	end

	// ------------------------------------------------------------------
	// serial output, changes on falling clock edges
	// ------------------------------------------------------------------
	always_comb begin
		case (dr_sel)
			dr_extest:   dr_tdo = bsr_shift_reg[0];
			dr_sample:   dr_tdo = bsr_shift_reg[0];
			dr_user1:    dr_tdo = user1_tdo;
			dr_user2:    dr_tdo = user2_tdo;
			dr_readback: dr_tdo = readback_bit;
			default:     dr_tdo = bypass_reg;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst || state_reg == st_reset) begin
			tdo_reg    <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end else if (tck_fall) begin
			tdo_reg    <= (state_reg == st_shift_ir) ? ir_shift_reg[0] : dr_tdo;
			tdo_oe_reg <= (state_reg == st_shift_ir) || (state_reg == st_shift_dr);
		end
	end

	// shared output pin: scan output when the option is chosen
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tdo_pin_out <= 1'b0;
			tdo_pin_oe  <= 1'b0;
		end else begin
			tdo_pin_out <= scan_option ? tdo_reg : user_pin_out;
			tdo_pin_oe  <= scan_option ? tdo_oe_reg : user_pin_oe;
		end
	end

endmodule

// ---- tb/boundary_scan_tap_props.sv ----
// Purpose: port assertions of boundary_scan_tap
// Assumes: one clock domain, synchronous active-high reset
// Notes:   attached by bind below
`timescale 1ns/100ps

module boundary_scan_tap_props
	import tap_pkg::*;
#(
	parameter int N_CELLS = 8
) (
	input wire logic               clk_sys,
	input wire logic               rst,
	input wire logic               scan_option,
	input wire logic               tdo_pin_oe,
	input wire logic [N_CELLS-1:0] pad_in,
	input wire logic [N_CELLS-1:0] pad_out,
	input wire logic [N_CELLS-1:0] pad_oe,
	input wire logic [N_CELLS-1:0] core_out,
	input wire logic [N_CELLS-1:0] core_oe,
	input wire logic [N_CELLS-1:0] core_in,
	input wire logic               user_reset,
	input wire logic               user_update,
	input wire logic               user_shift,
	input wire logic               user1_sel,
	input wire logic               user2_sel,
	input wire logic               cfg_bit_valid,
	input wire logic               readback_next
);
	// ------------------------------------------------------------------
	// cycles since reset
	// ------------------------------------------------------------------
	logic [3:0] age_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			age_reg <= 4'h0;
		end else if (age_reg != 4'hf) begin
			age_reg <= age_reg + 4'h1;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_parked;
		!scan_option [*4];
	endsequence
	sequence s_pads_quiet;
		($stable(pad_in) && age_reg > 4'h4) [*4];
	endsequence
	sequence s_core_quiet;
		(user_reset && $stable(core_out) && $stable(core_oe) && age_reg > 4'h4) [*4];
	endsequence

	AST_PARK_RESET: assert property (s_parked |-> user_reset)
		else $error("controller not parked");
	AST_TDO_IDLE: assert property ((scan_option && user_reset) [*4] |-> !tdo_pin_oe)
		else $error("scan output driven in reset");
	AST_ONE_USER: assert property (!(user1_sel && user2_sel))
		else $error("both user paths selected");
	AST_SHIFT_SEL: assert property (user_shift |-> (user1_sel || user2_sel))
		else $error("user shift without user path");
	AST_UPD_PULSE: assert property (user_update |-> (user1_sel || user2_sel) ##1 !user_update)
		else $error("bad user update pulse");
	AST_CFG_PULSE: assert property (cfg_bit_valid |=> !cfg_bit_valid)
		else $error("config strobe too long");
	AST_RB_PULSE: assert property (readback_next |=> !readback_next [*3])
		else $error("readback strobe too close");
	AST_RESET_QUIET: assert property (user_reset [*3] |-> !user_shift && !user1_sel && !user2_sel)
		else $error("user path active in reset");
	AST_CORE_IN: assert property (s_pads_quiet |-> core_in == pad_in)
		else $error("core input not following pad");
	AST_PADS_CORE: assert property (s_core_quiet |-> pad_out == core_out && pad_oe == core_oe)
		else $error("pads not following core");
endmodule

bind boundary_scan_tap boundary_scan_tap_props #(.N_CELLS(N_CELLS)) u_props (
	.clk_sys(clk_sys), .rst(rst), .scan_option(scan_option), .tdo_pin_oe(tdo_pin_oe),
	.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .core_out(core_out),
	.core_oe(core_oe), .core_in(core_in), .user_reset(user_reset), .user_update(user_update),
	.user_shift(user_shift), .user1_sel(user1_sel), .user2_sel(user2_sel),
	.cfg_bit_valid(cfg_bit_valid), .readback_next(readback_next)
);

// ---- tb/tap_ctrl_model.sv ----
// Purpose: behavioural boundary-scan test controller
// Assumes: tck half period 62.5 ns, far slower than clk_sys
// Notes:   tck stands high between frames
`timescale 1ns/100ps

module tap_ctrl_model (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo_pin_out,
	input  wire logic tdo_pin_oe
);
	// ------------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------------
	initial begin
		tck = 1'b1;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// fall and drive, sample tdo late in the low half, rise
	task automatic step(input logic m, input logic d, output logic q);
		tck = 1'b0;
		tms = m;
		tdi = d;
		#62.5;
		q = tdo_pin_oe ? tdo_pin_out : 1'bz;
		tck = 1'b1;
		#62.5;
	endtask

	// five rises with tms high, then idle
	task automatic reset_seq();
		logic q;
		repeat (5) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask

	// from idle: select, capture, shift n bits lsb first, update, idle
	task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b0, q);
		if (ir) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int k = 0; k < n; k++) begin
			step(k == n - 1, din[k], q);
			dout[k] = q;
		end
		step(1'b1, ~din[n-1], q);
		step(1'b0, din[n-1], q);
	endtask
endmodule

// ---- tb/test_boundary_scan_tap.sv ----
// Purpose: self-checking bench of boundary_scan_tap
// Assumes: tap_ctrl_model drives the test pins
// Notes:   every instruction code runs in four configuration phases
`timescale 1ns/100ps

module test_boundary_scan_tap
	import tap_pkg::*;
;
	localparam int          NC    = 4;
	localparam int          LIMIT = 40000;
	localparam logic [63:0] M     = 64'hfff;
	localparam logic [63:0] MI    = 64'h249;

	logic          clk_sys = 1'b0;
	logic          rst, scan_option, user_pin_out, user_pin_oe, config_active, config_done;
	logic          public_en, usercode_en, user1_tdo, user2_tdo, readback_bit;
	logic [NC-1:0] pad_in, core_out, core_oe, pad_out, pad_oe, core_in;
	logic          tdo_pin_out, tdo_pin_oe, user_reset, user_update, user_shift, user1_sel, user2_sel;
	logic          user_tdi, cfg_bit, cfg_bit_valid, readback_next, tck, tms, tdi;
	logic [31:0]   seed;
	logic [3:0]    ph [4] = '{4'h0, 4'h1, 4'h2, 4'he};
	logic          cfg_q [$];
	int            fails, checked, cyc, n_upd, n_sh, n_rb;

	boundary_scan_tap #(.N_CELLS(NC)) u_dut (
		.clk_sys(clk_sys), .rst(rst), .scan_option(scan_option), .tck_pin(tck), .tms_pin(tms),
		.tdi_pin(tdi), .tdo_pin_out(tdo_pin_out), .tdo_pin_oe(tdo_pin_oe), .user_pin_out(user_pin_out),
		.user_pin_oe(user_pin_oe), .config_active(config_active), .config_done(config_done),
		.public_en(public_en), .usercode_en(usercode_en), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
		.user_reset(user_reset), .user_update(user_update), .user_shift(user_shift),
		.user1_sel(user1_sel), .user2_sel(user2_sel), .user_tdi(user_tdi), .user1_tdo(user1_tdo),
		.user2_tdo(user2_tdo), .cfg_bit(cfg_bit), .cfg_bit_valid(cfg_bit_valid),
		.readback_next(readback_next), .readback_bit(readback_bit)
	);

	tap_ctrl_model u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo_pin_out(tdo_pin_out), .tdo_pin_oe(tdo_pin_oe));

	// ------------------------------------------------------------------
	// clock, monitors, timeout
	// ------------------------------------------------------------------
	always #5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cyc++;
		if (user_update === 1'b1) n_upd++;
		if (user_shift === 1'b1) n_sh++;
		if (readback_next === 1'b1) n_rb++;
		if (cfg_bit_valid === 1'b1) cfg_q.push_back(cfg_bit);
		if (cyc == LIMIT) begin
			fails++;
			tally_and_finish();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// instruction that takes effect in the present configuration phase
	function automatic int eff(input int c);
		if (c >= 6) return 7;
		if (config_done !== 1'b1) return (c == 1 || c == 5 || (c == 0 && config_active !== 1'b1)) ? c : 7;
		if (c == 2 || c == 3) return usercode_en ? c : 7;
		return public_en ? c : 7;
	endfunction

	// serial data expected out of the data path
	function automatic logic [63:0] model(input int e, input logic [63:0] d);
		logic [63:0] cap;
		cap = '0;
		for (int i = 0; i < NC; i++) begin
			cap[3*i+:3] = {core_oe[i], core_out[i], pad_in[i]};
		end
		case (e)
			0, 1: return cap;
			2: return M & {64{user1_tdo}};
			3: return M & {64{user2_tdo}};
			4: return M & {64{readback_bit}};
			default: return M & (d << 1);
		endcase
	endfunction

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		checked++;
		if (e !== g) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic settle();
		repeat (10) @(negedge clk_sys);
	endtask

	task automatic ir(input logic [2:0] code);
		logic [63:0] o;
		u_host.scan(1'b1, 3, {61'h0, code}, o);
		chk("ir_capture", 64'h1, o & 64'h7);
		settle();
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [63:0]   d, o, g;
		logic [NC-1:0] po, pe;
		int            e;
		{rst, scan_option, user_pin_out, user_pin_oe, config_active, config_done} = 6'h30;
		{public_en, usercode_en, user1_tdo, user2_tdo, readback_bit} = 5'h00;
		{pad_in, core_out, core_oe} = '0;
		seed = 32'h0001166e;
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		settle();
		chk("user_reset", 1, user_reset);
		scan_option = 1'b0;
		g = rnd();
		{user_pin_out, user_pin_oe} = g[1:0];
		repeat (4) u_host.step(1'b0, 1'b1, o[0]);
		settle();
		chk("tdo_pin_out", user_pin_out, tdo_pin_out);
		chk("tdo_pin_oe", user_pin_oe, tdo_pin_oe);
		chk("parked", 1, user_reset);
		scan_option = 1'b1;
		u_host.reset_seq();
		for (int p = 0; p < 4; p++) begin
			for (int c = 0; c < 8; c++) begin
				@(negedge clk_sys);
				{usercode_en, public_en, config_done, config_active} = ph[p];
				g = rnd();
				{pad_in, core_out, core_oe, user1_tdo, user2_tdo, readback_bit} = g[14:0];
				d = {52'h0, g[27:16]};
				e = eff(c);
				ir(3'(c));
				chk("user1_sel", e == 2, user1_sel);
				chk("user2_sel", e == 3, user2_sel);
				n_upd = 0;
				n_sh = 0;
				n_rb = 0;
				cfg_q.delete();
				u_host.scan(1'b0, 12, d, o);
				settle();
				chk("dr_out", model(e, d) & MI, o & MI);
				chk("core_capture", model(e, d) & M & ~MI, o & M & ~MI);
				for (int i = 0; i < NC; i++) begin
					po[i] = e == 0 ? d[3*i+1] : core_out[i];
					pe[i] = e == 0 ? d[3*i+2] : core_oe[i];
				end
				chk("pad_out", po, pad_out);
				chk("pad_oe", pe, pad_oe);
				chk("core_in", pad_in, core_in);
				chk("user_tdi", tdi, user_tdi);
				chk("user_update", e == 2 || e == 3, n_upd);
				chk("user_shift", e == 2 || e == 3, n_sh != 0);
				chk("readback_next", e == 4 ? 12 : 0, n_rb);
				g = '0;
				foreach (cfg_q[k]) g[k] = cfg_q[k];
				chk("cfg_bits", e == 5 ? d : 0, g);
				chk("cfg_count", e == 5 ? 12 : 0, cfg_q.size());
			end
		end
		ir(3'h2);
		chk("user1_sel", 1, user1_sel);
		repeat (5) u_host.step(1'b1, 1'b0, o[0]);
		settle();
		chk("user_reset", 1, user_reset);
		chk("user1_sel", 0, user1_sel);
		tally_and_finish();
	end
endmodule
